// ---- include/mcpwm_pkg.sv ----
//------------------------------------------------------------
// motor coil pwm controller constants
//------------------------------------------------------------
package mcpwm_pkg;

    //------------------------------------------------------------
    // sizes
    //------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int CNT_W = 11;

    //------------------------------------------------------------
    // register byte addresses
    //------------------------------------------------------------
    localparam logic [7:0] ADDR_CTL0 = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_CHCTL0 = 8'h10;
    localparam logic [7:0] ADDR_DUTY0 = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h30;

    //------------------------------------------------------------
    // control register 0 fields
    //------------------------------------------------------------
    localparam int CTL0_PRE_LSB = 5;
    localparam int CTL0_FAST_BIT = 3;
    localparam int CTL0_DITHER_SELECT_BIT = 2;

    //------------------------------------------------------------
    // channel control fields
    //------------------------------------------------------------
    localparam int CHC_MODE_LSB = 6;
    localparam int CHC_ALIGN_LSB = 4;
    localparam int CHC_SIGN_BIT = 0;

    //------------------------------------------------------------
    // reset values
    //------------------------------------------------------------
    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [10:0] PERIOD_RST = 11'h000;
    localparam logic [7:0] CHCTL_RST = 8'h00;
    localparam logic [15:0] DUTY_RST = 16'h0000;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        MCPWM_HALF_A = 2'b00,
        MCPWM_HALF_B = 2'b01,
        MCPWM_FULL = 2'b10,
        MCPWM_DUAL = 2'b11
    } mcpwm_mode_t;

    typedef enum logic [1:0] {
        MCPWM_OFF = 2'b00,
        MCPWM_LEFT = 2'b01,
        MCPWM_RIGHT = 2'b10,
        MCPWM_CENTER = 2'b11
    } mcpwm_align_t;

endpackage

// ---- logic/mcpwm_channel.sv ----
`timescale 1ns/100ps
// one pwm channel: compare, alignment, pin mapping
module mcpwm_channel
    import mcpwm_pkg::*;
(
    // clock
    input wire logic aclk,
    input wire logic aresetn,
    // timing
    input wire logic tick,
    input wire logic [10:0] cnt,
    input wire logic down,
    input wire logic period_start,
    input wire logic odd_period,
    input wire logic [10:0] period_top,
    // settings
    input wire logic fast,
    input wire logic dither,
    input wire logic [1:0] mode,
    input wire logic [1:0] align,
    input wire logic [15:0] duty,
    // pins
    output logic minus_pin,
    output logic plus_pin
);
    typedef struct packed {
        logic [10:0] cmp;
        logic minus;
        logic plus;
    } mcpwm_ch_st_t;
    mcpwm_ch_st_t st_reg, st_next;
    logic sign;
    logic [10:0] mag;
    logic pwm;
    logic [11:0] ctr_lo;

    // latch compare at period start so edges stay glitch free
    always_comb begin
        st_next = st_reg;
        sign = duty[15];
        // byte vs word interpretation of the duty value
        if (fast) begin
            mag = {duty[14:8], 4'h0};
        end else begin
            mag = duty[10:0];
        end
        if (period_start) begin
            // dither adds one lsb to an odd duty on odd periods and drops it on the others
            if (dither && !fast && odd_period && mag[0]) begin
                st_next.cmp = mag + 11'h001;
            end else if (dither && !fast) begin
                st_next.cmp = {mag[10:1], 1'b0};
            end else begin
                st_next.cmp = mag;
            end
        end
        // centre pulse starts half the off time into the period
        ctr_lo = ({1'b0, period_top} + 12'h001 - {1'b0, st_reg.cmp}) >> 1;
        case (align)
            MCPWM_LEFT: pwm = cnt < st_reg.cmp;
            // right pulse ends with the period; 12 bits keep the sum from wrapping
            MCPWM_RIGHT: pwm = ({1'b0, cnt} + {1'b0, st_reg.cmp}) > {1'b0, period_top};
            MCPWM_CENTER: pwm = (st_reg.cmp > period_top)
                || ({1'b0, cnt} >= ctr_lo && {1'b0, cnt} < ctr_lo + {1'b0, st_reg.cmp});
            default: pwm = 1'b0;
        endcase
        if (align == MCPWM_OFF) begin
            st_next.minus = 1'b0;
            st_next.plus = 1'b0;
        end else if (tick || period_start) begin
            case (mode)
                MCPWM_HALF_A: begin
                    st_next.minus = pwm;
                    st_next.plus = 1'b0;
                end
                MCPWM_HALF_B: begin
                    st_next.minus = 1'b0;
                    st_next.plus = pwm;
                end
                default: begin
                    // pwm on minus with plus high is positive current
                    st_next.minus = sign ? 1'b0 : pwm;
                    st_next.plus = sign ? pwm : 1'b1;
                end
            endcase
        end
        if (down) begin
            st_next.cmp = st_next.cmp;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign minus_pin = st_reg.minus;
    assign plus_pin = st_reg.plus;
endmodule

// ---- logic/mcpwm_top.sv ----
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
// four channel motor coil pwm controller with axi4-lite registers
module mcpwm_top
    import mcpwm_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // motor 0 pins
    output logic motor0_coil0_minus_pin,
    output logic motor0_coil0_plus_pin,
    output logic motor0_coil1_minus_pin,
    output logic motor0_coil1_plus_pin,
    // motor 1 pins
    output logic motor1_coil0_minus_pin,
    output logic motor1_coil0_plus_pin,
    output logic motor1_coil1_minus_pin,
    output logic motor1_coil1_plus_pin
);
    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctl0;
        logic [10:0] period;
        logic [3:0][7:0] chctl;
        logic [3:0][15:0] duty;
        logic [1:0] pre_act;
        logic [2:0] pre_cnt;
        logic [10:0] cnt;
        logic down;
        logic odd;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awready;
        logic wready;
        logic arready;
    } mcpwm_st_t;
    mcpwm_st_t st_reg, st_next;

    logic tick;
    logic period_start;
    logic [10:0] top;
    logic [7:0] idx;
    logic [3:0] pin_m;
    logic [3:0] pin_p;
    logic [2:0] pre_div;

    //------------------------------------------------------------
    // period and prescale decode
    //------------------------------------------------------------
    // prescaler divides by 1, 2, 4 or 8
    always_comb begin
        pre_div = 3'h0;
        case (st_reg.pre_act)
            2'b00: pre_div = 3'h0;
            2'b01: pre_div = 3'h1;
            2'b10: pre_div = 3'h3;
            default: pre_div = 3'h7;
        endcase
        // zero period counts the full 11-bit range
        top = (st_reg.period == 11'h000) ? 11'h7ff : st_reg.period;
    end
    assign tick = (st_reg.pre_cnt == pre_div);
    assign period_start = tick && !st_reg.down && (st_reg.cnt == 11'h000);

    //------------------------------------------------------------
    // next state: counter and register bus
    //------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        idx = 8'h00;
        // prescaled counter; centre channels share the same up count
        st_next.pre_cnt = tick ? 3'h0 : st_reg.pre_cnt + 3'h1;
        if (tick) begin
            if (st_reg.cnt >= top) begin
                st_next.cnt = 11'h000;
                st_next.odd = ~st_reg.odd;
                // new prescale only takes hold at the period boundary
                st_next.pre_act = st_reg.ctl0[CTL0_PRE_LSB+:2];
            end else begin
                st_next.cnt = st_reg.cnt + 11'h001;
            end
        end
        st_next.down = 1'b0;
        // write address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_got = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            idx = st_reg.aw_addr;
            if ({idx[7:2], 2'b00} == ADDR_CTL0) begin
                if (st_reg.w_strb[0]) begin
                    st_next.ctl0 = st_reg.w_data[7:0];
                end
            end else if ({idx[7:2], 2'b00} == ADDR_PERIOD) begin
                if (st_reg.w_strb[0]) begin
                    st_next.period[7:0] = st_reg.w_data[7:0];
                end
                if (st_reg.w_strb[1]) begin
                    st_next.period[10:8] = st_reg.w_data[10:8];
                end
            end else if (idx[7:4] == ADDR_CHCTL0[7:4] && idx[1:0] == 2'b00) begin
                if (st_reg.w_strb[0]) begin
                    st_next.chctl[idx[3:2]] = st_reg.w_data[7:0];
                end
            end else if (idx[7:4] == ADDR_DUTY0[7:4] && idx[1:0] == 2'b00) begin
                // fast mode: the high byte alone updates the duty
                if (st_reg.w_strb[1]) begin
                    st_next.duty[idx[3:2]][15:8] = st_reg.w_data[15:8];
                end
                if (st_reg.w_strb[0] && !st_reg.ctl0[CTL0_FAST_BIT]) begin
                    st_next.duty[idx[3:2]][7:0] = st_reg.w_data[7:0];
                end
            end else begin
                st_next.bresp = RESP_SLVERR;
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // read path answers one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            if ({s_axi_araddr[7:2], 2'b00} == ADDR_CTL0) begin
                st_next.rdata = {24'h00_0000, st_reg.ctl0};
            end else if ({s_axi_araddr[7:2], 2'b00} == ADDR_PERIOD) begin
                st_next.rdata = {21'h00_0000, st_reg.period};
            end else if (s_axi_araddr[7:4] == ADDR_CHCTL0[7:4] && s_axi_araddr[1:0] == 2'b00) begin
                st_next.rdata = {24'h00_0000, st_reg.chctl[s_axi_araddr[3:2]]};
            end else if (s_axi_araddr[7:4] == ADDR_DUTY0[7:4] && s_axi_araddr[1:0] == 2'b00) begin
                st_next.rdata = {16'h0000, st_reg.duty[s_axi_araddr[3:2]]};
            end else if ({s_axi_araddr[7:2], 2'b00} == ADDR_STATUS) begin
                // live counter state for software
                st_next.rdata = {18'h0_0000, st_reg.odd, st_reg.pre_act, st_reg.cnt};
            end else begin
                st_next.rresp = RESP_SLVERR;
            end
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        // readies registered so every bus output leaves a flip-flop
        st_next.awready = !st_next.aw_got && !st_next.bvalid;
        st_next.wready = !st_next.w_got && !st_next.bvalid;
        st_next.arready = !st_next.rvalid;
    end

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    // all channels off after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.ctl0 <= CTL0_RST;
            st_reg.period <= PERIOD_RST;
            st_reg.chctl <= {NUM_CH{CHCTL_RST}};
            st_reg.duty <= {NUM_CH{DUTY_RST}};
            // readies up in reset to match the idle flags
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ready terms held off while a transfer is in flight
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    //------------------------------------------------------------
    // channels
    //------------------------------------------------------------
    // each channel owns a minus/plus pair; pairs are 0-1 and 2-3
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
            mcpwm_channel u_ch (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(tick),
                .cnt(st_reg.cnt),
                .down(st_reg.down),
                .period_start(period_start),
                .odd_period(st_reg.odd),
                .period_top(top),
                .fast(st_reg.ctl0[CTL0_FAST_BIT]),
                .dither(st_reg.ctl0[CTL0_DITHER_SELECT_BIT]),
                .mode(st_reg.chctl[ch][CHC_MODE_LSB+:2]),
                .align(st_reg.chctl[ch][CHC_ALIGN_LSB+:2]),
                .duty(st_reg.duty[ch]),
                .minus_pin(pin_m[ch]),
                .plus_pin(pin_p[ch])
            );
        end
    endgenerate

    // pin order: motor, then coil, minus before plus
    assign motor0_coil0_minus_pin = pin_m[0];
    assign motor0_coil0_plus_pin = pin_p[0];
    assign motor0_coil1_minus_pin = pin_m[1];
    assign motor0_coil1_plus_pin = pin_p[1];
    assign motor1_coil0_minus_pin = pin_m[2];
    assign motor1_coil0_plus_pin = pin_p[2];
    assign motor1_coil1_minus_pin = pin_m[3];
    assign motor1_coil1_plus_pin = pin_p[3];
endmodule

// ---- testbench/mcpwm_top_properties.sv ----
`timescale 1ns/100ps
// watches the bus handshake and the pins at the top ports
module mcpwm_top_properties (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic motor0_coil0_minus_pin,
    input wire logic motor0_coil0_plus_pin,
    input wire logic motor0_coil1_minus_pin,
    input wire logic motor0_coil1_plus_pin,
    input wire logic motor1_coil0_minus_pin,
    input wire logic motor1_coil0_plus_pin,
    input wire logic motor1_coil1_minus_pin,
    input wire logic motor1_coil1_plus_pin
);
    logic [7:0] pins;
    // all eight pins in one word
    assign pins = {motor1_coil1_plus_pin, motor1_coil1_minus_pin, motor1_coil0_plus_pin, motor1_coil0_minus_pin,
        motor0_coil1_plus_pin, motor0_coil1_minus_pin, motor0_coil0_plus_pin, motor0_coil0_minus_pin};
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    pins_idle_a: assert property ($rose(aresetn) |-> pins == 8'h00)
        else $error("pins active right after reset");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    read_idle_a: assert property (!s_axi_rvalid |-> s_axi_arready)
        else $error("read address not accepted when idle");
    bvalid_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
endmodule
bind mcpwm_top mcpwm_top_properties u_props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .motor0_coil0_minus_pin, .motor0_coil0_plus_pin, .motor0_coil1_minus_pin, .motor0_coil1_plus_pin,
    .motor1_coil0_minus_pin, .motor1_coil0_plus_pin, .motor1_coil1_minus_pin, .motor1_coil1_plus_pin
);

// ---- testbench/mcpwm_coil_model.sv ----
`timescale 1ns/100ps
// coil load: pin high time and widths of the drive pulses
module mcpwm_coil_model (
    // clock
    input wire logic aclk,
    input wire logic clr,
    // coil ends
    input wire logic minus_pin,
    input wire logic plus_pin,
    // measurements
    output int mcnt,
    output int pcnt,
    output int last_w,
    output int prev_w
);
    int run;
    logic armed;
    // current flows only while the ends differ; a pulse cut by clr is not counted
    always @(posedge aclk) begin
        if (clr) begin
            mcnt <= 0;
            pcnt <= 0;
            run <= 0;
            armed <= 1'b0;
            last_w <= 0;
            prev_w <= 0;
        end else begin
            mcnt <= mcnt + int'(minus_pin);
            pcnt <= pcnt + int'(plus_pin);
            if (minus_pin ^ plus_pin) begin
                run <= armed ? run + 1 : 0;
            end else begin
                armed <= 1'b1;
                if (armed && run != 0) begin
                    prev_w <= last_w;
                    last_w <= run;
                end
                run <= 0;
            end
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top
    import mcpwm_pkg::*;
;
    logic aclk, aresetn, clr;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb, mp, pp;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic motor0_coil0_minus_pin, motor0_coil0_plus_pin, motor0_coil1_minus_pin, motor0_coil1_plus_pin;
    logic motor1_coil0_minus_pin, motor1_coil0_plus_pin, motor1_coil1_minus_pin, motor1_coil1_plus_pin;
    logic [1:0] wr_q [$];
    logic [33:0] rd_q [$];
    int mcnt [4], pcnt [4], lw [4], pw [4], aw [4], fw [4];
    int num_errors, compares, k, m, s, p, j, w0;
    integer seed;
    mcpwm_top u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .motor0_coil0_minus_pin, .motor0_coil0_plus_pin, .motor0_coil1_minus_pin, .motor0_coil1_plus_pin,
        .motor1_coil0_minus_pin, .motor1_coil0_plus_pin, .motor1_coil1_minus_pin, .motor1_coil1_plus_pin
    );
    // coil i sits on the minus/plus pair of channel i
    assign mp = {motor1_coil1_minus_pin, motor1_coil0_minus_pin, motor0_coil1_minus_pin, motor0_coil0_minus_pin};
    assign pp = {motor1_coil1_plus_pin, motor1_coil0_plus_pin, motor0_coil1_plus_pin, motor0_coil0_plus_pin};
    for (genvar i = 0; i < 4; i++) begin : g_coil
        mcpwm_coil_model u_coil (.aclk, .clr, .minus_pin(mp[i]), .plus_pin(pp[i]),
            .mcnt(mcnt[i]), .pcnt(pcnt[i]), .last_w(lw[i]), .prev_w(pw[i]));
    end
    always #5 aclk = ~aclk;
    //----------------------------------------
    // checking and bus tasks
    //----------------------------------------
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // answers are compared against the oldest note as they are accepted
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready && wr_q.size() > 0)
            check(34'(s_axi_bresp), 34'(wr_q.pop_front()));
        if (s_axi_rvalid && s_axi_rready && rd_q.size() > 0)
            check({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    end
    // ready held low at random until the answer is up, so the answer must stand
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        logic done;
        n = 0;
        wr_q.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($random(seed));
        do begin
            @(posedge aclk);
            n++;
            done = s_axi_bvalid && s_axi_bready;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end while (!done && n < 100);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        if (!done) begin
            num_errors++;
            give_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
        int n;
        logic done;
        n = 0;
        rd_q.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($random(seed));
        do begin
            @(posedge aclk);
            n++;
            done = s_axi_rvalid && s_axi_rready;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end while (!done && n < 100);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (!done) begin
            num_errors++;
            give_verdict();
        end
    endtask
    // let settings reach a period start, then count over w cycles
    task automatic measure(input int settle, input int w);
        repeat (settle) @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (w) @(posedge aclk);
        #1;
    endtask
    //----------------------------------------
    // main sequence
    //----------------------------------------
    initial begin
        aclk = 0;
        aresetn = 0;
        clr = 0;
        seed = 32'hf1b8349e;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        num_errors = 0;
        compares = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        measure(0, 40);
        for (k = 0; k < 4; k++) check(34'(mcnt[k] + pcnt[k]), 34'd0);
        rd(ADDR_CTL0, RESP_OKAY, 32'h0);
        rd(ADDR_PERIOD, RESP_OKAY, 32'h0);
        rd(8'h04, RESP_SLVERR, 32'h0);
        wr(8'h04, 32'hffffffff, RESP_SLVERR);
        v = $random(seed) & 32'h6c;
        wr(ADDR_CTL0, v, RESP_OKAY);
        rd(ADDR_CTL0, RESP_OKAY, v);
        // a random fast bit turns the duty registers into byte mode
        s = int'(v[CTL0_FAST_BIT]);
        for (k = 0; k < 4; k++) begin
            rd(ADDR_CHCTL0 + 8'(4 * k), RESP_OKAY, 32'h0);
            rd(ADDR_DUTY0 + 8'(4 * k), RESP_OKAY, 32'h0);
            v = $random(seed) & 32'h87ff;
            wr(ADDR_DUTY0 + 8'(4 * k), v, RESP_OKAY);
            rd(ADDR_DUTY0 + 8'(4 * k), RESP_OKAY, (s != 0) ? (v & 32'hff00) : v);
        end
        wr(ADDR_PERIOD, 32'd16, RESP_OKAY);
        wr(ADDR_CTL0, 32'h0, RESP_OKAY);
        // every channel, output mode and sign alone, left aligned
        for (k = 0; k < 4; k++) begin
            for (m = 0; m < 8; m++) begin
                s = m & 1;
                wr(ADDR_DUTY0 + 8'(4 * k), {16'h0, s[0], 15'd5}, RESP_OKAY);
                wr(ADDR_CHCTL0 + 8'(4 * k), {24'h0, m[2:1], 2'b01, 4'h0}, RESP_OKAY);
                measure(40, 64);
                for (j = 0; j < 4; j++) if (j != k) check(34'(mcnt[j] + pcnt[j]), 34'd0);
                if (m >= 4) begin
                    check(34'(s ? mcnt[k] : pcnt[k]), s ? 34'd0 : 34'd64);
                    check(34'((s ? pcnt[k] : mcnt[k]) inside {[1:63]}), 34'd1);
                end else
                    check(34'((mcnt[k] == 0) != (pcnt[k] == 0)), 34'd1);
            end
            wr(ADDR_CHCTL0 + 8'(4 * k), 32'h0, RESP_OKAY);
        end
        // pulse width scales with the prescaler
        wr(ADDR_CHCTL0, 32'h90, RESP_OKAY);
        wr(ADDR_DUTY0, 32'h5, RESP_OKAY);
        for (p = 0; p < 4; p++) begin
            wr(ADDR_CTL0, 32'(p << 5), RESP_OKAY);
            measure(300, 400);
            w0 = 17 - 5; // off ticks of duty 5 in a 17 tick period
            check(34'(lw[0]), 34'(w0 << p));
        end
        wr(ADDR_CTL0, 32'h0, RESP_OKAY);
        for (p = 0; p < 4; p++) begin
            wr(ADDR_CHCTL0, 32'h80 | 32'(p << 4), RESP_OKAY);
            measure(40, 64);
            aw[p] = lw[0];
            if (p == 0) check(34'(mcnt[0] + pcnt[0]), 34'd0);
        end
        check(34'(aw[1]), 34'(aw[2]));
        check(34'(aw[3]), 34'(aw[1]));
        // dither: odd duty alternates widths, even or off does not
        wr(ADDR_CHCTL0, 32'h90, RESP_OKAY);
        for (j = 0; j < 3; j++) begin
            wr(ADDR_CTL0, (j < 2) ? 32'h4 : 32'h0, RESP_OKAY);
            wr(ADDR_DUTY0, (j == 1) ? 32'h6 : 32'h5, RESP_OKAY);
            measure(40, 64);
            check(34'(lw[0] != pw[0]), 34'(j == 0));
        end
        // fast mode ignores the low duty byte, word mode does not
        wr(ADDR_PERIOD, 32'h400, RESP_OKAY);
        for (j = 0; j < 4; j++) begin
            wr(ADDR_CTL0, (j < 2) ? 32'h8 : 32'h0, RESP_OKAY);
            wr(ADDR_DUTY0, j[0] ? 32'h0aff : 32'h0a00, RESP_OKAY);
            measure(2100, 2100);
            fw[j] = lw[0];
        end
        check(34'(fw[0]), 34'(fw[1]));
        // 7-bit value 0x0a scales to 160 of a 1025 tick period
        check(34'(fw[0]), 34'(1025 - 160));
        check(34'(fw[2] != fw[3]), 34'd1);
        give_verdict();
    end
endmodule
